/* File: adcr_config_regs.sv */
// Configuration register bank of a dual-channel converter behind its serial port
//
// Summary of operation
// - First channel correction enable, bit 15 reg 01
// - Second channel correction enable, bit 9 reg 01
// - Bit 3 reg 01: two's complement or offset binary
// - Threshold field sets over-range level in sixteenths
// - Over-range flag follows overload after 12 clocks
// - Threshold field resets to fifteen
// - One threshold serves both channels
// - Reg 03 bit 14: run or clear first channel
// - Reg 1A bit 14: run or clear second channel
// - Reg 0E sync field: off, one-shot, pins
// - Reg 0F sync field uses same coding
// - One-shot sync fires once until rewritten
// - Reg 0F bits 6:4 select voltage reference
// - Serial port, three-wire or four-wire data pins
// - Reset key restores defaults, key register reads zero
`timescale 1ns/1ps
module adcr_config_regs
  import adcr_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_nrst,
  // Serial configuration port
  input  wire adcr_spi_in_t          i_spi,
  output adcr_spi_out_t              o_spi,
  // Clock generator sync
  input  wire logic                  i_sync_pin,
  output logic                       o_clkgen_sync,
  // Converter samples
  input  wire logic [ADCR_SMP_W-1:0] i_first_channel_sample,
  input  wire logic [ADCR_SMP_W-1:0] i_second_channel_sample,
  // Over-range flags
  output logic                       o_first_channel_over_range_flag,
  output logic                       o_second_channel_over_range_flag,
  // Correction loop controls
  output logic                       o_first_channel_corr_run,
  output logic                       o_first_channel_corr_clear,
  output logic                       o_second_channel_corr_run,
  output logic                       o_second_channel_corr_clear,
  // Output format and analog settings
  output logic                       o_offset_binary,
  output logic                       o_performance_tuning_bit,
  output logic [2:0]                 o_vref_sel,
  output logic                       o_external_ref
);

  typedef struct packed {
    adcr_cfg_t       cfg;
    logic            sclk_q;
    logic            sync_q;
    logic [4:0]      bit_cnt;
    logic            rw;
    logic [7:0]      addr;
    logic [15:0]     shin;
    logic [15:0]     shout;
    logic            rd_active;
    logic            armed;
    adcr_sync_mode_t sync_mode;
    adcr_spi_out_t   spi;
    logic            sync_pulse;
    logic            c1_run;
    logic            c1_clr;
    logic            c2_run;
    logic            c2_clr;
    logic            fmt;
    logic            tune;
    logic [2:0]      vref;
    logic            ext_ref;
  } adcr_main_state_t;

  adcr_main_state_t           s;
  adcr_main_state_t           next_s;
  logic [ADCR_SYNC_W-1:0]     pins;
  logic                       sclk_rise;
  logic                       sclk_fall;
  logic                       sync_edge;
  logic                       wr_now;
  logic                       wr_key;
  logic [15:0]                wr_data;
  logic [7:0]                 rd_addr;

  function automatic logic [15:0] reg_read(input adcr_cfg_t c, input logic [7:0] a);
    logic [15:0] d;
    d = 16'h0000;
    unique case (a)
      ADCR_A_PORT: d = c.port;
      ADCR_A_CFC:  d = c.cfc;
      ADCR_A_OVR:  d = c.ovr;
      ADCR_A_C1:   d = c.c1;
      ADCR_A_SYL:  d = c.syl;
      ADCR_A_SYH:  d = c.syh;
      ADCR_A_C2:   d = c.c2;
      // Reset key register self-clears, unmapped reads zero
      default:     d = 16'h0000;
    endcase
    return d;
  endfunction

  // Both fields must agree; any other pairing leaves sync off
  function automatic adcr_sync_mode_t sync_decode(input logic [13:0] lo, input logic [3:0] hi);
    adcr_sync_mode_t m;
    m = ADCR_SYNC_BAD;
    if (lo == ADCR_SYL_OFF && hi == ADCR_SYH_OFF)
      m = ADCR_SYNC_OFF;
    else if (lo == ADCR_SYL_ONCE && hi == ADCR_SYH_ONCE)
      m = ADCR_SYNC_ONCE;
    else if (lo == ADCR_SYL_PIN && hi == ADCR_SYH_PIN)
      m = ADCR_SYNC_PIN;
    return m;
  endfunction

  // Pins come from the host's domain; the serial clock is oversampled, so it
  // must run well below a quarter of the local clock
  adcr_sync2 u_sync (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_async ({i_sync_pin, i_spi.sdio, i_spi.sen_n, i_spi.sclk}),
    .o_sync  (pins)
  );

  always_comb
  begin
    next_s    = s;
    wr_now    = 1'b0;
    wr_key    = 1'b0;
    wr_data   = {s.shin[14:0], pins[ADCR_L_SDIO]};
    rd_addr   = {s.addr[6:0], pins[ADCR_L_SDIO]};
    sclk_rise = pins[ADCR_L_SCLK] && !s.sclk_q;
    sclk_fall = !pins[ADCR_L_SCLK] && s.sclk_q;
    sync_edge = pins[ADCR_L_SYNC] && !s.sync_q;
    next_s.sclk_q = pins[ADCR_L_SCLK];
    next_s.sync_q = pins[ADCR_L_SYNC];

    // Frame handling: deselect aborts any partial frame without a write
    if (pins[ADCR_L_SEN])
    begin
      next_s.bit_cnt   = 5'h00;
      next_s.rd_active = 1'b0;
    end
    else if (sclk_rise)
    begin
      if (s.bit_cnt == 5'h00)
        next_s.rw = pins[ADCR_L_SDIO];
      else if (s.bit_cnt <= ADCR_ADDR_LAST)
        next_s.addr = rd_addr;
      else
        next_s.shin = wr_data;
      if (s.bit_cnt <= ADCR_FRAME_LAST)
        next_s.bit_cnt = s.bit_cnt + 5'h01;
      if (s.bit_cnt == ADCR_ADDR_LAST && s.rw)
      begin
        next_s.shout     = reg_read(s.cfg, rd_addr);
        next_s.rd_active = 1'b1;
      end
      wr_now = (s.bit_cnt == ADCR_FRAME_LAST) && !s.rw;
    end
    else if (sclk_fall && s.rd_active && s.bit_cnt >= ADCR_SHIFT_FIRST)
    begin
      // Host samples on the rising edge, so data moves on the falling one
      next_s.shout = {s.shout[14:0], 1'b0};
    end

    // Clock generator sync
    next_s.sync_mode  = sync_decode(s.cfg.syl[ADCR_B_SYL_HI:ADCR_B_SYL_LO],
                                    s.cfg.syh[ADCR_B_SYH_HI:ADCR_B_SYH_LO]);
    next_s.sync_pulse = 1'b0;
    unique case (s.sync_mode)
      ADCR_SYNC_ONCE:
      begin
        if (sync_edge && s.armed)
        begin
          next_s.sync_pulse = 1'b1;
          next_s.armed      = 1'b0;
        end
      end
      ADCR_SYNC_PIN:
        next_s.sync_pulse = sync_edge;
      ADCR_SYNC_OFF, ADCR_SYNC_BAD:
        next_s.sync_pulse = 1'b0;
    endcase

    // Register writes; rewriting a sync field re-arms the one-shot
    if (wr_now)
    begin
      case (s.addr)
        ADCR_A_PORT: next_s.cfg.port = wr_data & ADCR_M_PORT;
        ADCR_A_CFC:  next_s.cfg.cfc  = wr_data & ADCR_M_CFC;
        ADCR_A_OVR:  next_s.cfg.ovr  = wr_data & ADCR_M_OVR;
        ADCR_A_C1:   next_s.cfg.c1   = wr_data & ADCR_M_CORR;
        ADCR_A_C2:   next_s.cfg.c2   = wr_data & ADCR_M_CORR;
        ADCR_A_SYL:
        begin
          next_s.cfg.syl = wr_data & ADCR_M_SYL;
          next_s.armed   = 1'b1;
        end
        ADCR_A_SYH:
        begin
          next_s.cfg.syh = wr_data & ADCR_M_SYH;
          next_s.armed   = 1'b1;
        end
        ADCR_A_SRST:
        begin
          if (wr_data == ADCR_SRST_KEY)
          begin
            wr_key       = 1'b1;
            next_s.cfg   = ADCR_CFG_RESET;
            next_s.armed = 1'b1;
          end
        end
        // Unmapped addresses are ignored
        default: next_s.cfg = s.cfg;
      endcase
    end

    if (!i_nrst)
    begin
      next_s           = '0;
      next_s.cfg       = ADCR_CFG_RESET;
      next_s.armed     = 1'b1;
      next_s.sync_mode = ADCR_SYNC_PIN;
      next_s.sclk_q    = 1'b0;
    end

    // Registered outputs follow the next configuration
    next_s.c1_run  = next_s.cfg.cfc[ADCR_B_C1_EN]
                     && !next_s.cfg.c1[ADCR_B_CORR_START];
    next_s.c1_clr  = next_s.cfg.c1[ADCR_B_CORR_START];
    next_s.c2_run  = next_s.cfg.cfc[ADCR_B_C2_EN]
                     && !next_s.cfg.c2[ADCR_B_CORR_START];
    next_s.c2_clr  = next_s.cfg.c2[ADCR_B_CORR_START];
    next_s.fmt     = next_s.cfg.cfc[ADCR_B_FMT];
    next_s.tune    = next_s.cfg.cfc[ADCR_B_TUNE];
    next_s.vref    = next_s.cfg.syh[ADCR_B_VREF_HI:ADCR_B_VREF_LO];
    next_s.ext_ref = next_s.vref > ADCR_VREF_LAST_INT;
    // Three-wire mode turns the data pin round for the read data phase
    next_s.spi.sdio      = next_s.shout[15];
    next_s.spi.sdio_oe_n = !(next_s.rd_active && !next_s.cfg.port[ADCR_B_FOUR_WIRE]);
    next_s.spi.serial_data_out       = next_s.cfg.port[ADCR_B_FOUR_WIRE] && next_s.shout[15];
  end

  always_ff @(posedge i_mclk)
  begin
    s <= next_s;
  end

  // One threshold field drives both detectors
  adcr_ovr_det u_ovr_first (
    .i_mclk   (i_mclk),
    .i_nrst   (i_nrst),
    .i_sample (i_first_channel_sample),
    .i_thresh (s.cfg.ovr[ADCR_B_THR_HI:ADCR_B_THR_LO]),
    .o_flag   (o_first_channel_over_range_flag)
  );

  adcr_ovr_det u_ovr_second (
    .i_mclk   (i_mclk),
    .i_nrst   (i_nrst),
    .i_sample (i_second_channel_sample),
    .i_thresh (s.cfg.ovr[ADCR_B_THR_HI:ADCR_B_THR_LO]),
    .o_flag   (o_second_channel_over_range_flag)
  );

  assign o_spi                       = s.spi;
  assign o_clkgen_sync               = s.sync_pulse;
  assign o_first_channel_corr_run    = s.c1_run;
  assign o_first_channel_corr_clear  = s.c1_clr;
  assign o_second_channel_corr_run   = s.c2_run;
  assign o_second_channel_corr_clear = s.c2_clr;
  assign o_offset_binary             = s.fmt;
  assign o_performance_tuning_bit    = s.tune;
  assign o_vref_sel                  = s.vref;
  assign o_external_ref              = s.ext_ref;

  soft_reset_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    wr_key |=> (s.cfg == ADCR_CFG_RESET) && o_first_channel_corr_clear && !o_offset_binary)
    else $error("reset key did not restore defaults");
  thresh_default_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    wr_key |=> s.cfg.ovr[ADCR_B_THR_HI:ADCR_B_THR_LO] == 4'hf)
    else $error("threshold not fifteen after reset key");
  first_corr_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (wr_now && s.addr == ADCR_A_CFC) |=> o_first_channel_corr_run
      == ($past(wr_data[ADCR_B_C1_EN]) && !o_first_channel_corr_clear))
    else $error("first channel correction run wrong");
  second_corr_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (wr_now && s.addr == ADCR_A_C2) |=> o_second_channel_corr_clear == $past(wr_data[14]))
    else $error("second channel correction start not applied");
  data_format_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (wr_now && s.addr == ADCR_A_CFC) |=> o_offset_binary == $past(wr_data[3]))
    else $error("output coding not applied");
  ovr_shared_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_first_channel_sample == i_second_channel_sample) && $stable(s.cfg.ovr)
    |-> ##12 (o_first_channel_over_range_flag == o_second_channel_over_range_flag))
    else $error("channels disagree on same input");
  one_shot_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (s.sync_mode == ADCR_SYNC_ONCE && !s.armed) |=> !o_clkgen_sync)
    else $error("one-shot sync fired twice");
  sync_off_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (s.sync_mode inside {ADCR_SYNC_OFF, ADCR_SYNC_BAD}) |=> !o_clkgen_sync)
    else $error("sync pulse while sync disabled");
  vref_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (wr_now && s.addr == ADCR_A_SYH) |=> o_external_ref
      == ($past(wr_data[ADCR_B_VREF_HI:ADCR_B_VREF_LO]) > ADCR_VREF_LAST_INT))
    else $error("reference selection decode wrong");
  three_wire_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    s.rd_active && !s.cfg.port[ADCR_B_FOUR_WIRE] |-> !o_spi.sdio_oe_n && !o_spi.serial_data_out)
    else $error("three-wire read not driven on data pin");

  // Each write lands, masked, in the cycle after the frame's last bit
  first_start_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (wr_now && s.addr == ADCR_A_C1) |=> o_first_channel_corr_clear
      == $past(wr_data[ADCR_B_CORR_START]))
    else $error("first channel correction start not applied");
  second_enable_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (wr_now && s.addr == ADCR_A_CFC) |=> o_second_channel_corr_run
      == ($past(wr_data[ADCR_B_C2_EN]) && !o_second_channel_corr_clear))
    else $error("second channel correction run wrong");
  thresh_write_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (wr_now && s.addr == ADCR_A_OVR) |=> s.cfg.ovr == ($past(wr_data) & ADCR_M_OVR))
    else $error("threshold write not applied");
  vref_write_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (wr_now && s.addr == ADCR_A_SYH)
    |=> o_vref_sel == $past(wr_data[ADCR_B_VREF_HI:ADCR_B_VREF_LO]))
    else $error("reference selection not applied");
  sync_rearm_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (wr_now && s.addr == ADCR_A_SYL)
    |=> s.armed && s.cfg.syl == ($past(wr_data) & ADCR_M_SYL))
    else $error("sync select write did not re-arm");
  pin_sync_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (s.sync_mode == ADCR_SYNC_PIN && sync_edge) |=> o_clkgen_sync)
    else $error("sync pin edge not passed on");
  one_shot_fire_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (s.sync_mode == ADCR_SYNC_ONCE && s.armed && sync_edge) |=> o_clkgen_sync)
    else $error("armed one-shot sync did not fire");
  sync_match_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (s.cfg.syl[ADCR_B_SYL_HI:ADCR_B_SYL_LO] == ADCR_SYL_ONCE
     && s.cfg.syh[ADCR_B_SYH_HI:ADCR_B_SYH_LO] == ADCR_SYH_ONCE)
    |=> s.sync_mode == ADCR_SYNC_ONCE)
    else $error("one-shot sync codes not decoded");
  sync_unsupported_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (&s.cfg.syl[ADCR_B_SYL_HI:ADCR_B_SYL_LO]) |=> s.sync_mode == ADCR_SYNC_BAD)
    else $error("unsupported sync code not refused");
  frame_abort_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    pins[ADCR_L_SEN] |=> s.bit_cnt == 5'h00 && !s.rd_active)
    else $error("deselect did not end the frame");
  key_read_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (!pins[ADCR_L_SEN] && sclk_rise && s.rw && s.bit_cnt == ADCR_ADDR_LAST
     && rd_addr == ADCR_A_SRST) |=> s.shout == 16'h0000)
    else $error("reset key register did not read zero");

endmodule // adcr_config_regs

/* File: adcr_host_model.sv */
// Behavioural host that drives the serial configuration port of the bank
`timescale 1ns/1ps
module adcr_host_model
  import adcr_pkg::*;
(
  // Clock
  input  wire logic          i_mclk,
  // Device side of the port
  input  wire adcr_spi_out_t i_dev,
  output adcr_spi_in_t       o_spi
);
  logic sclk  = 1'h0;
  logic sen_n = 1'h1;
  logic drv   = 1'h0;
  logic rel   = 1'h0;
  logic four  = 1'h0;

  // A released pin shows the inverse of its last level, so stale data never reads as valid
  assign o_spi = '{sclk: sclk, sen_n: sen_n,
                   sdio: !i_dev.sdio_oe_n ? i_dev.sdio : (rel ? ~drv : drv)};

  // Phases of five clocks keep each serial level well above the synchroniser delay
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    logic [24:0] f;
    f = {rd, a, d};
    q = '0;
    sen_n = 1'h0;
    for (int i = 24; i >= 0; i--)
    begin
      // Let go of the pin only after the last address bit has been taken
      rel = rd && i < 16;
      if (!rel)
        drv = f[i];
      sclk = 1'h0;
      repeat (5) @(negedge i_mclk);
      if (rd && i < 16)
        q[i] = four ? i_dev.serial_data_out : o_spi.sdio;
      sclk = 1'h1;
      repeat (5) @(negedge i_mclk);
    end
    sen_n = 1'h1;
    rel = 1'h0;
    repeat (6) @(negedge i_mclk);
  endtask
endmodule // adcr_host_model

/* File: adcr_ovr_det.sv */
// Over-range comparator with fixed detection latency for one channel
`timescale 1ns/1ps
module adcr_ovr_det
  import adcr_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_nrst,
  // Sample and shared threshold
  input  wire logic [ADCR_SMP_W-1:0] i_sample,
  input  wire logic [3:0]            i_thresh,
  // Flag
  output logic                       o_flag
);

  typedef struct packed {
    logic [ADCR_OVR_LATENCY-1:0] pipe;
  } adcr_ovr_state_t;

  adcr_ovr_state_t s;
  adcr_ovr_state_t next_s;
  logic            over;

  // Core words are two's complement; -full scale maps to 12'h800
  function automatic logic [ADCR_SMP_W-1:0] magnitude(input logic [ADCR_SMP_W-1:0] v);
    return v[ADCR_SMP_W-1] ? ADCR_SMP_W'(~v + 1'b1) : v;
  endfunction

  always_comb
  begin
    next_s = s;
    // Level is threshold/16 of full scale
    over = magnitude(i_sample) > {1'b0, i_thresh, ADCR_THR_STEP};
    next_s.pipe = {s.pipe[ADCR_OVR_LATENCY-2:0], over};
    if (!i_nrst)
    begin
      next_s.pipe = '0;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    s <= next_s;
  end

  assign o_flag = s.pipe[ADCR_OVR_LATENCY-1];

  ovr_rise_late_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    over |-> ##12 o_flag) else $error("over-range flag missing 12 cycles after overload");
  ovr_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !over |-> ##12 !o_flag) else $error("over-range flag without overload");

endmodule // adcr_ovr_det

/* File: adcr_pkg.sv */
// Package: addresses, reset values, field layouts and types of the converter configuration bank
package adcr_pkg;

  // Register addresses
  localparam logic [7:0] ADCR_A_PORT = 8'h00;
  localparam logic [7:0] ADCR_A_CFC  = 8'h01;
  localparam logic [7:0] ADCR_A_OVR  = 8'h02;
  localparam logic [7:0] ADCR_A_C1   = 8'h03;
  localparam logic [7:0] ADCR_A_SYL  = 8'h0e;
  localparam logic [7:0] ADCR_A_SYH  = 8'h0f;
  localparam logic [7:0] ADCR_A_C2   = 8'h1a;
  localparam logic [7:0] ADCR_A_SRST = 8'h2c;

  // Reset values
  localparam logic [15:0] ADCR_R_PORT = 16'h0000;
  localparam logic [15:0] ADCR_R_CFC  = 16'h0002;
  localparam logic [15:0] ADCR_R_OVR  = 16'h0780;
  localparam logic [15:0] ADCR_R_CORR = 16'h4b18;
  localparam logic [15:0] ADCR_R_SYL  = 16'haaa8;
  localparam logic [15:0] ADCR_R_SYH  = 16'ha000;
  localparam logic [15:0] ADCR_SRST_KEY = 16'hd2f0;

  // Writable bits; the rest read as zero
  localparam logic [15:0] ADCR_M_PORT = 16'h8000;
  localparam logic [15:0] ADCR_M_CFC  = 16'h820a;
  localparam logic [15:0] ADCR_M_OVR  = 16'h0780;
  localparam logic [15:0] ADCR_M_CORR = 16'hffff;
  localparam logic [15:0] ADCR_M_SYL  = 16'hfffc;
  localparam logic [15:0] ADCR_M_SYH  = 16'hf070;

  // Field positions
  localparam int ADCR_B_FOUR_WIRE  = 15;
  localparam int ADCR_B_C1_EN      = 15;
  localparam int ADCR_B_C2_EN      = 9;
  localparam int ADCR_B_FMT        = 3;
  localparam int ADCR_B_TUNE       = 1;
  localparam int ADCR_B_CORR_START = 14;
  localparam int ADCR_B_THR_HI     = 10;
  localparam int ADCR_B_THR_LO     = 7;
  localparam int ADCR_B_SYL_HI     = 15;
  localparam int ADCR_B_SYL_LO     = 2;
  localparam int ADCR_B_SYH_HI     = 15;
  localparam int ADCR_B_SYH_LO     = 12;
  localparam int ADCR_B_VREF_HI    = 6;
  localparam int ADCR_B_VREF_LO    = 4;

  // Sync select and reference codes
  localparam logic [13:0] ADCR_SYL_OFF  = 14'h0000;
  localparam logic [13:0] ADCR_SYL_ONCE = 14'h1555;
  localparam logic [13:0] ADCR_SYL_PIN  = 14'h2aaa;
  localparam logic [3:0]  ADCR_SYH_OFF  = 4'h0;
  localparam logic [3:0]  ADCR_SYH_ONCE = 4'h5;
  localparam logic [3:0]  ADCR_SYH_PIN  = 4'ha;
  localparam logic [2:0]  ADCR_VREF_LAST_INT = 3'h4;

  // Serial frame: read flag, 8 address bits, 16 data bits, MSB first
  localparam logic [4:0] ADCR_ADDR_LAST   = 5'h08;
  localparam logic [4:0] ADCR_SHIFT_FIRST = 5'h0a;
  localparam logic [4:0] ADCR_FRAME_LAST  = 5'h18;

  // Over-range detector
  localparam int         ADCR_OVR_LATENCY = 12;
  localparam int         ADCR_SMP_W       = 12;
  localparam logic [6:0] ADCR_THR_STEP    = 7'h00;

  // Synchroniser lanes and their idle levels
  localparam int         ADCR_SYNC_W  = 4;
  localparam int         ADCR_L_SCLK  = 0;
  localparam int         ADCR_L_SEN   = 1;
  localparam int         ADCR_L_SDIO  = 2;
  localparam int         ADCR_L_SYNC  = 3;
  localparam logic [3:0] ADCR_SYNC_RST = 4'h2;

  typedef struct packed {
    logic [15:0] port;
    logic [15:0] cfc;
    logic [15:0] ovr;
    logic [15:0] c1;
    logic [15:0] syl;
    logic [15:0] syh;
    logic [15:0] c2;
  } adcr_cfg_t;

  localparam adcr_cfg_t ADCR_CFG_RESET = '{port: ADCR_R_PORT, cfc: ADCR_R_CFC,
    ovr: ADCR_R_OVR, c1: ADCR_R_CORR, syl: ADCR_R_SYL, syh: ADCR_R_SYH, c2: ADCR_R_CORR};

  typedef enum logic [1:0] {ADCR_SYNC_OFF, ADCR_SYNC_ONCE, ADCR_SYNC_PIN, ADCR_SYNC_BAD}
    adcr_sync_mode_t;

  typedef struct packed {
    logic sclk;
    logic sen_n;
    logic sdio;
  } adcr_spi_in_t;

  typedef struct packed {
    logic sdio;
    logic sdio_oe_n;
    logic serial_data_out;
  } adcr_spi_out_t;

endpackage

/* File: adcr_sync2.sv */
// Two-flop synchroniser for the pins of the configuration bank
`timescale 1ns/1ps
module adcr_sync2
  import adcr_pkg::*;
(
  // Clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_nrst,
  // Lanes
  input  wire logic [ADCR_SYNC_W-1:0] i_async,
  output logic      [ADCR_SYNC_W-1:0] o_sync
);

  typedef struct packed {
    logic [ADCR_SYNC_W-1:0] meta;
    logic [ADCR_SYNC_W-1:0] stable;
  } adcr_sync_state_t;

  adcr_sync_state_t s;
  adcr_sync_state_t next_s;

  always_comb
  begin
    next_s        = s;
    next_s.meta   = i_async;
    next_s.stable = s.meta;
    if (!i_nrst)
    begin
      next_s.meta   = ADCR_SYNC_RST;
      next_s.stable = ADCR_SYNC_RST;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    s <= next_s;
  end

  assign o_sync = s.stable;

endmodule // adcr_sync2

/* File: testbench.sv */
// Self-checking testbench of the converter configuration bank
`timescale 1ns/1ps
module testbench;
  import adcr_pkg::*;
  logic                  i_mclk   = 1'h0;
  logic                  i_nrst   = 1'h0;
  logic                  sync_pin = 1'h0;
  logic [ADCR_SMP_W-1:0] smp_a    = '0;
  logic [ADCR_SMP_W-1:0] smp_b    = '0;
  adcr_spi_in_t          spi_in;
  adcr_spi_out_t         spi_out;
  logic                  cg_sync, flag_a, flag_b, run_a, clr_a, run_b, clr_b, obin, tune, ext;
  logic [2:0]            vref;
  logic [15:0]           rd;
  logic [15:0]           d;
  logic [1:0]            eq[$];
  int                    errors  = 0;
  int                    n_tests = 0;
  int                    pulses  = 0;
  logic [7:0]            ra[7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0e, 8'h0f, 8'h1a};
  logic [15:0]           rv[7] = '{16'h0000, 16'h0002, 16'h0780, 16'h4b18, 16'haaa8,
                                   16'ha000, 16'h4b18};

  adcr_config_regs dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_spi(spi_in), .o_spi(spi_out),
    .i_sync_pin(sync_pin), .o_clkgen_sync(cg_sync), .i_first_channel_sample(smp_a),
    .i_second_channel_sample(smp_b), .o_first_channel_over_range_flag(flag_a),
    .o_second_channel_over_range_flag(flag_b), .o_first_channel_corr_run(run_a),
    .o_first_channel_corr_clear(clr_a), .o_second_channel_corr_run(run_b),
    .o_second_channel_corr_clear(clr_b), .o_offset_binary(obin),
    .o_performance_tuning_bit(tune), .o_vref_sel(vref), .o_external_ref(ext));
  adcr_host_model host (.i_mclk(i_mclk), .i_dev(spi_out), .o_spi(spi_in));

  initial
  begin
    forever #10 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk)
  begin
    if (cg_sync === 1'h1)
      pulses++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    host.xfer(1'h0, a, v, rd);
  endtask

  task automatic table_check();
    for (int k = 0; k < 7; k++)
    begin
      host.xfer(1'h1, ra[k], 16'h0000, rd);
      check(rd, rv[k], "reset value");
    end
    check({run_a, clr_a, run_b, clr_b, obin, tune, vref, ext, 6'h00},
          {4'h5, 2'h1, 4'h0, 6'h00}, "reset outputs");
  endtask

  task automatic sync_edges(input int n, input int exp);
    pulses = 0;
    repeat (n)
    begin
      sync_pin = 1'h1;
      repeat (8) @(negedge i_mclk);
      sync_pin = 1'h0;
      repeat (8) @(negedge i_mclk);
    end
    check(16'(pulses), 16'(exp), "sync pulses");
  endtask

  function automatic logic [11:0] pick(input logic [3:0] t);
    logic [11:0] b;
    b = {1'h0, t, 7'h00};
    case ($urandom_range(4))
      0: return b;
      1: return b + 12'h001;
      2: return 12'h000 - b - 12'h001;
      3: return 12'h800;
      default: return 12'($urandom);
    endcase
  endfunction

  function automatic logic over(input logic [11:0] s, input logic [3:0] t);
    int v;
    v = $signed(s);
    if (v < 0)
      v = -v;
    return v > int'(t) * 128;
  endfunction

  // One threshold feeds both detectors, so both flags are judged against it
  task automatic ovr_run(input logic [3:0] t, input int n);
    wr(ADCR_A_OVR, {5'h00, t, 7'h00});
    eq.delete();
    repeat (n)
    begin
      @(negedge i_mclk);
      if (eq.size() == 12)
        check({14'h0, flag_a, flag_b}, {14'h0, eq.pop_front()}, "over range");
      smp_a = pick(t);
      smp_b = pick(t);
      eq.push_back({over(smp_a, t), over(smp_b, t)});
    end
  endtask

  initial
  begin
    void'($urandom(32'hd3ee91ed));
    repeat (20) @(negedge i_mclk);
    i_nrst = 1'h1;
    repeat (3) @(negedge i_mclk);
    table_check();
    wr(ADCR_A_PORT, 16'h8000);
    host.four = 1'h1;
    repeat (6)
    begin
      d = 16'($urandom) | 16'h0002;
      wr(ADCR_A_CFC, d);
      host.xfer(1'h1, ADCR_A_CFC, 16'h0000, rd);
      check(rd, d & ADCR_M_CFC, "format register");
      // A loop is started only on a channel whose correction is enabled
      wr(ADCR_A_C1, 16'h0b18 | {1'h0, d[4] | ~d[15], 14'h0000});
      wr(ADCR_A_C2, 16'h0b18 | {1'h0, d[5] | ~d[9], 14'h0000});
      check({obin, tune}, {d[3], 1'h1}, "format outputs");
      check({run_a, clr_a, run_b, clr_b}, {d[15] & ~d[4], d[4] | ~d[15], d[9] & ~d[5],
            d[5] | ~d[9]}, "correction");
    end
    for (int k = 0; k < 8; k++)
    begin
      wr(ADCR_A_SYH, {4'ha, 5'h00, 3'(k), 4'h0});
      check({12'h0, ext, vref}, {12'h0, k > 4, 3'(k)}, "reference");
    end
    sync_edges(2, 2);
    wr(ADCR_A_SYL, 16'h5554);
    wr(ADCR_A_SYH, 16'h5000);
    sync_edges(3, 1);
    wr(ADCR_A_SYH, 16'h5000);
    sync_edges(2, 1);
    wr(ADCR_A_SYL, 16'h0000);
    wr(ADCR_A_SYH, 16'h0000);
    sync_edges(2, 0);
    wr(ADCR_A_SYL, 16'hfffc);
    wr(ADCR_A_SYH, 16'hf000);
    sync_edges(2, 0);
    ovr_run(4'h0, 120);
    ovr_run(4'($urandom_range(14, 1)), 150);
    ovr_run(4'hf, 150);
    host.xfer(1'h1, 8'h55, 16'h0000, rd);
    check(rd, 16'h0000, "unmapped read");
    wr(8'h2c, 16'hd2f1);
    host.xfer(1'h1, ADCR_A_SYH, 16'h0000, rd);
    check(rd, 16'hf000, "bad key ignored");
    wr(8'h2c, 16'hd2f0);
    host.four = 1'h0;
    host.xfer(1'h1, 8'h2c, 16'h0000, rd);
    check(rd, 16'h0000, "key register");
    table_check();
    end_of_test();
  end

  initial
  begin
    repeat (60000) @(posedge i_mclk);
    errors++;
    end_of_test();
  end
endmodule // testbench
